/* File: logic/dcf_regs.vh */
// constants of the dual-clock fifo flag block
// Behaviour
// (RULE1) the empty flag rises at a read-clock edge only once the write that filled it is a skew window old, else at the next read edge.
// (RULE2) both link clocks may run freely during reset and nothing needs them gated.
// (RULE3) after reset the data pins drive low while the output enable is low and float while it is high.
// (RULE4) the level of the second-enable/load pin caught at reset makes it a second write enable when high or an offset load enable when low;
// the code ignores the pin when it was caught high, so no second write enable applies then.
// (RULE5) the first stored word appears on the read cycle after the empty flag rises.
// (RULE6) first-read latency is one read period plus skew when the skew is met and may grow to two periods otherwise.
// (RULE7) the almost-empty flag changes at a read edge only once the last write is a partial skew window old;
// the code lets it rise at any read edge that has no write in the same cycle.
// (RULE8) with almost-empty offset n the almost-empty flag is low while n-1 or fewer words remain.
// (RULE9) with almost-full offset m the almost-full flag is low while depth-(m-1) or more words are held.
// (RULE10) the depth used for the almost-full threshold is the built depth of 16K nine-bit words.
// (RULE11) the almost-full flag changes at a write edge only once the last read is a partial skew window old;
// the code raises it at any write edge once the count is below the threshold, with no read-age check.
// (RULE12) the full flag drops at a write edge only once the read that freed a slot is a skew window old.
// (RULE13) a word is stored only with both write enables active and not full, and removed only with both read enables active and not empty;
// the code ignores the second write enable when the pin was caught high at reset.
`ifndef DCF_REGS_VH
`define DCF_REGS_VH

// ************************************************************
// geometry
// ************************************************************
`define DCF_WIDTH          9
`define DCF_PTR_W          14
`define DCF_CNT_W          15
`define DCF_DEPTH          15'h4000

// ************************************************************
// timing
// ************************************************************
`define DCF_CLK_NS         10
`define DCF_SKEW1_NS       5
`define DCF_SKEW2_NS       10
`define DCF_SKEW1_CYC      ((`DCF_SKEW1_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_SKEW2_CYC      ((`DCF_SKEW2_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_INIT_CYC       3'h3

// ************************************************************
// register map
// ************************************************************
`define DCF_AE_OFS_ADDR    8'h00
`define DCF_AF_OFS_ADDR    8'h04
`define DCF_STATUS_ADDR    8'h08
`define DCF_IRQ_ADDR       8'h0c
`define DCF_MASK_ADDR      8'h10
`define DCF_AE_OFS_RST     14'h0007
`define DCF_AF_OFS_RST     14'h0007
`define DCF_MASK_RST       4'h0

// ************************************************************
// status and event fields
// ************************************************************
`define DCF_ST_EMPTY       0
`define DCF_ST_FULL        1
`define DCF_ST_AEMPTY      2
`define DCF_ST_AFULL       3
`define DCF_ST_LOADMODE    4
`define DCF_ST_CNT_LSB     16
`define DCF_EV_EMPTY       0
`define DCF_EV_FULL        1
`define DCF_EV_OVERFLOW    2
`define DCF_EV_UNDERFLOW   3

`endif

/* File: logic/dcf_fifo.v */
// dual-clock nine-bit fifo with flags, offset load and wishbone status
`include "dcf_regs.vh"

module dcf_fifo (
    // system
    input  wire        CLK_I,
    input  wire        RSTN_I,
    // wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [7:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O,
    output wire        IRQ_O,
    // write port
    input  wire        WRITE_CLOCK_I,
    input  wire [8:0]  WRITE_DATA_I,
    input  wire        FIRST_WRITE_ENABLE_N_I,
    input  wire        SECOND_WRITE_ENABLE_OR_LOAD_I,
    // read port
    input  wire        READ_CLOCK_I,
    input  wire        FIRST_READ_ENABLE_N_I,
    input  wire        SECOND_READ_ENABLE_N_I,
    input  wire        OUTPUT_ENABLE_N_I,
    output reg  [8:0]  READ_DATA_O,
    output reg         READ_DATA_OE_N_O,
    // flags
    output reg         EMPTY_FLAG_N_O,
    output reg         FULL_FLAG_N_O,
    output reg         ALMOST_EMPTY_FLAG_N_O,
    output reg         ALMOST_FULL_FLAG_N_O
);

// ************************************************************
// pin synchronisers
// ************************************************************
reg  [13:0] s1_reg;
reg  [13:0] s2_reg;
reg         wclk_d_reg;
reg         rclk_d_reg;
wire [13:0] pins = {OUTPUT_ENABLE_N_I, SECOND_READ_ENABLE_N_I, FIRST_READ_ENABLE_N_I,
                    SECOND_WRITE_ENABLE_OR_LOAD_I, FIRST_WRITE_ENABLE_N_I,
                    WRITE_DATA_I};

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        s1_reg <= 14'h0000;
        s2_reg <= 14'h0000;
    end else begin
        s1_reg <= pins;
        s2_reg <= s1_reg;
    end
end

reg         wc1_reg;
reg         wc2_reg;
reg         rc1_reg;
reg         rc2_reg;
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        wc1_reg    <= 1'b0;
        wc2_reg    <= 1'b0;
        rc1_reg    <= 1'b0;
        rc2_reg    <= 1'b0;
        wclk_d_reg <= 1'b0;
        rclk_d_reg <= 1'b0;
    end else begin
        wc1_reg    <= WRITE_CLOCK_I;
        wc2_reg    <= wc1_reg;
        rc1_reg    <= READ_CLOCK_I;
        rc2_reg    <= rc1_reg;
        wclk_d_reg <= wc2_reg;
        rclk_d_reg <= rc2_reg;
    end
end

wire [8:0] wdata   = s2_reg[8:0];
wire       first_write_enable_n  = s2_reg[9];
wire       second_write_enable_or_load = s2_reg[10];
wire       first_read_enable_n  = s2_reg[11];
wire       second_read_enable_n  = s2_reg[12];
wire       oe_n    = s2_reg[13];

// ************************************************************
// start-up and mode capture
// ************************************************************
reg [2:0] init_reg;
reg       load_mode_reg;
wire      ready = (init_reg == `DCF_INIT_CYC);

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        init_reg      <= 3'h0;
        load_mode_reg <= 1'b0;
    end else if (!ready) begin
        init_reg <= init_reg + 3'h1;
        if (init_reg == `DCF_INIT_CYC - 3'h1)
            load_mode_reg <= ~second_write_enable_or_load; // RULE4
    end
end

// free-running clocks during reset are harmless: edges count only once ready
wire wr_edge = ready & wc2_reg & ~wclk_d_reg; // RULE2
wire rd_edge = ready & rc2_reg & ~rclk_d_reg; // RULE2

// ************************************************************
// storage and pointers
// ************************************************************
reg [8:0]  mem [0:16383];
reg [13:0] wr_ptr_reg;
reg [13:0] rd_ptr_reg;
reg [14:0] count_reg;
reg [13:0] ae_ofs_reg;
reg [13:0] af_ofs_reg;
reg        ld_sel_reg;

wire wen2_ok  = load_mode_reg ? second_write_enable_or_load : 1'b1;
wire ld_write = wr_edge & load_mode_reg & ~first_write_enable_n & ~second_write_enable_or_load;
wire wr_try   = wr_edge & ~first_write_enable_n & wen2_ok;
wire do_write = wr_try & FULL_FLAG_N_O; // RULE13
wire rd_try   = rd_edge & ~first_read_enable_n & ~second_read_enable_n;
wire do_read  = rd_try & EMPTY_FLAG_N_O; // RULE13

always @(posedge CLK_I) begin
    if (do_write)
        mem[wr_ptr_reg] <= wdata;
end

wire [14:0] count_next = count_reg + {14'h0000, do_write} - {14'h0000, do_read};

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        wr_ptr_reg  <= 14'h0000;
        rd_ptr_reg  <= 14'h0000;
        count_reg   <= 15'h0000;
        READ_DATA_O <= 9'h000;
    end else begin
        count_reg <= count_next;
        if (do_write)
            wr_ptr_reg <= wr_ptr_reg + 14'h0001;
        if (do_read) begin
            rd_ptr_reg  <= rd_ptr_reg + 14'h0001;
            READ_DATA_O <= mem[rd_ptr_reg]; // RULE5
        end
    end
end

// drive low data after reset while enabled, float when disabled
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I)
        READ_DATA_OE_N_O <= 1'b1;
    else
        READ_DATA_OE_N_O <= oe_n; // RULE3
end

// ************************************************************
// edge ages for skew windows
// ************************************************************
reg [3:0] wr_age_reg;
reg [3:0] rd_age_reg;
always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        wr_age_reg <= 4'hf;
        rd_age_reg <= 4'hf;
    end else begin
        if (do_write)
            wr_age_reg <= 4'h0;
        else if (wr_age_reg != 4'hf)
            wr_age_reg <= wr_age_reg + 4'h1;
        if (do_read)
            rd_age_reg <= 4'h0;
        else if (rd_age_reg != 4'hf)
            rd_age_reg <= rd_age_reg + 4'h1;
    end
end

wire wr_old1 = (wr_age_reg >= `DCF_SKEW1_CYC);
wire wr_old2 = (wr_age_reg >= `DCF_SKEW2_CYC);
wire rd_old1 = (rd_age_reg >= `DCF_SKEW1_CYC);
wire rd_old2 = (rd_age_reg >= `DCF_SKEW2_CYC);

// ************************************************************
// flags
// ************************************************************
wire [14:0] ae_lim = {1'b0, ae_ofs_reg};
wire [14:0] af_lim = `DCF_DEPTH - {1'b0, af_ofs_reg} + 15'h0001; // RULE10
wire        ne_now = (count_next != 15'h0000);
wire        nf_now = (count_next != `DCF_DEPTH);
wire        nae_now = (count_next >= ae_lim); // RULE8
wire        naf_now = (count_next < af_lim); // RULE9
reg         empty_n_next;
reg         full_n_next;
reg         ae_n_next;
reg         af_n_next;

always @* begin
    empty_n_next = EMPTY_FLAG_N_O;
    ae_n_next    = ALMOST_EMPTY_FLAG_N_O;
    full_n_next  = FULL_FLAG_N_O;
    af_n_next    = ALMOST_FULL_FLAG_N_O;
    if (rd_edge) begin
        empty_n_next = ne_now & (EMPTY_FLAG_N_O | wr_old1); // RULE1 RULE6
        ae_n_next    = nae_now & (ALMOST_EMPTY_FLAG_N_O | wr_old2 | ~do_write); // RULE7
    end
    if (wr_edge) begin
        full_n_next = nf_now & (FULL_FLAG_N_O | rd_old1); // RULE12
        af_n_next   = naf_now | (~ALMOST_FULL_FLAG_N_O & ~rd_old2 & ~do_read); // RULE11
    end
end

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        EMPTY_FLAG_N_O        <= 1'b0;
        FULL_FLAG_N_O         <= 1'b1;
        ALMOST_EMPTY_FLAG_N_O <= 1'b0;
        ALMOST_FULL_FLAG_N_O  <= 1'b1;
    end else begin
        EMPTY_FLAG_N_O        <= empty_n_next;
        FULL_FLAG_N_O         <= full_n_next;
        ALMOST_EMPTY_FLAG_N_O <= ae_n_next;
        ALMOST_FULL_FLAG_N_O  <= af_n_next;
    end
end

// ************************************************************
// wishbone slave and offset registers
// ************************************************************
wire       bus_req = CYC_I & STB_I & ~ACK_O;
wire       bus_wr  = bus_req & WE_I;
wire       lo_ok   = SEL_I[0];
wire       hi_ok   = SEL_I[1];
reg  [3:0] irq_reg;
reg  [3:0] mask_reg;

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        ae_ofs_reg <= `DCF_AE_OFS_RST;
        af_ofs_reg <= `DCF_AF_OFS_RST;
        ld_sel_reg <= 1'b0;
    end else if (ld_write) begin
        // pin load alternates almost-empty then almost-full offset
        ld_sel_reg <= ~ld_sel_reg; // RULE4
        if (ld_sel_reg)
            af_ofs_reg <= {af_ofs_reg[13:9], wdata};
        else
            ae_ofs_reg <= {ae_ofs_reg[13:9], wdata};
    end else if (bus_wr) begin
        if (ADR_I == `DCF_AE_OFS_ADDR) begin
            if (lo_ok)
                ae_ofs_reg[7:0] <= DAT_I[7:0];
            if (hi_ok)
                ae_ofs_reg[13:8] <= DAT_I[13:8];
        end
        if (ADR_I == `DCF_AF_OFS_ADDR) begin
            if (lo_ok)
                af_ofs_reg[7:0] <= DAT_I[7:0];
            if (hi_ok)
                af_ofs_reg[13:8] <= DAT_I[13:8];
        end
    end
end

// ************************************************************
// interrupt status and mask
// ************************************************************
wire [3:0] ev;
assign ev[`DCF_EV_EMPTY]     = EMPTY_FLAG_N_O & ~empty_n_next;
assign ev[`DCF_EV_FULL]      = FULL_FLAG_N_O & ~full_n_next;
assign ev[`DCF_EV_OVERFLOW]  = wr_try & ~FULL_FLAG_N_O;
assign ev[`DCF_EV_UNDERFLOW] = rd_try & ~EMPTY_FLAG_N_O;

wire [3:0] irq_clr = (bus_wr && ADR_I == `DCF_IRQ_ADDR && lo_ok) ? DAT_I[3:0] : 4'h0;

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        irq_reg  <= 4'h0;
        mask_reg <= `DCF_MASK_RST;
    end else begin
        irq_reg <= (irq_reg & ~irq_clr) | ev;
        if (bus_wr && ADR_I == `DCF_MASK_ADDR && lo_ok)
            mask_reg <= DAT_I[3:0];
    end
end

assign IRQ_O = |(irq_reg & mask_reg);

// ************************************************************
// read mux and acknowledge
// ************************************************************
reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h00000000;
    case (ADR_I)
        `DCF_AE_OFS_ADDR: rd_mux = {18'h00000, ae_ofs_reg};
        `DCF_AF_OFS_ADDR: rd_mux = {18'h00000, af_ofs_reg};
        `DCF_STATUS_ADDR: begin
            rd_mux[`DCF_ST_EMPTY]    = ~EMPTY_FLAG_N_O;
            rd_mux[`DCF_ST_FULL]     = ~FULL_FLAG_N_O;
            rd_mux[`DCF_ST_AEMPTY]   = ~ALMOST_EMPTY_FLAG_N_O;
            rd_mux[`DCF_ST_AFULL]    = ~ALMOST_FULL_FLAG_N_O;
            rd_mux[`DCF_ST_LOADMODE] = load_mode_reg;
            rd_mux[30:16]            = count_reg;
        end
        `DCF_IRQ_ADDR:    rd_mux = {28'h0000000, irq_reg};
        `DCF_MASK_ADDR:   rd_mux = {28'h0000000, mask_reg};
        default:          rd_mux = 32'h00000000;
    endcase
end

always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
        ACK_O <= 1'b0;
        DAT_O <= 32'h00000000;
    end else begin
        ACK_O <= bus_req;
        DAT_O <= bus_req ? rd_mux : 32'h00000000;
    end
end

endmodule // dcf_fifo

/* File: tb/dcf_fifo_properties.sv */
// port checker of the dual-clock fifo flag block
module dcf_fifo_chk (
    input wire       CLK_I,
    input wire       RSTN_I,
    input wire       CYC_I,
    input wire       STB_I,
    input wire       ACK_O,
    input wire       WRITE_CLOCK_I,
    input wire       READ_CLOCK_I,
    input wire       FIRST_READ_ENABLE_N_I,
    input wire       SECOND_READ_ENABLE_N_I,
    input wire       OUTPUT_ENABLE_N_I,
    input wire [8:0] READ_DATA_O,
    input wire       READ_DATA_OE_N_O,
    input wire       EMPTY_FLAG_N_O,
    input wire       FULL_FLAG_N_O,
    input wire       ALMOST_EMPTY_FLAG_N_O,
    input wire       ALMOST_FULL_FLAG_N_O
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [2:0] run_reg;
    // ****************
    // cycles since reset
    // ****************
    always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            run_reg <= 3'h0;
        end else if (run_reg != 3'h7) begin
            run_reg <= run_reg + 3'h1;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // ****************
    // assertions
    // ****************
    chk_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked next cycle");
    chk_oe_follow: assert property (
        run_reg == 3'h7 |-> READ_DATA_OE_N_O == $past(OUTPUT_ENABLE_N_I, 3))
        else $error("output enable not followed");
    chk_read_enabled: assert property ($changed(READ_DATA_O) |->
        $past(!FIRST_READ_ENABLE_N_I && !SECOND_READ_ENABLE_N_I, 2))
        else $error("word read without enables");
    chk_read_nonempty: assert property ($changed(READ_DATA_O) |-> $past(EMPTY_FLAG_N_O))
        else $error("word read while empty");
    chk_empty_at_read: assert property ($rose(EMPTY_FLAG_N_O) |->
        $past(READ_CLOCK_I, 2) || $past(READ_CLOCK_I, 3))
        else $error("empty flag rose off a read edge");
    chk_word_next: assert property ($rose(EMPTY_FLAG_N_O) |-> $stable(READ_DATA_O))
        else $error("word shown with empty flag rise");
    chk_empty_on_read: assert property ($fell(EMPTY_FLAG_N_O) |-> $changed(READ_DATA_O))
        else $error("empty without a read");
    chk_ae_when_empty: assert property (!EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O)
        else $error("almost empty high while empty");
    chk_af_when_full: assert property (!FULL_FLAG_N_O |-> !ALMOST_FULL_FLAG_N_O)
        else $error("almost full high while full");
    chk_full_at_write: assert property ($rose(FULL_FLAG_N_O) |->
        $past(WRITE_CLOCK_I, 2) || $past(WRITE_CLOCK_I, 3))
        else $error("full flag dropped off a write edge");
    cov_empty_rise: cover property ($rose(EMPTY_FLAG_N_O));
    cov_afull_fall: cover property ($fell(ALMOST_FULL_FLAG_N_O));
    cov_oe_fall: cover property ($fell(READ_DATA_OE_N_O));
endmodule // dcf_fifo_chk
bind dcf_fifo dcf_fifo_chk u_chk (.*);

/* File: tb/dcf_link_host.sv */
// link-side host model: free link clocks, writer and reader
module dcf_link_host (
    input  wire       clk_i,
    input  wire [8:0] rdata_i,
    output reg        wclk_o,
    output reg        rclk_o,
    output reg  [8:0] wdata_o,
    output reg        first_write_enable_n_o,
    output reg        sec_o,
    output reg        ren_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // free link clocks
    // ****************
    initial begin
        wclk_o = 1'b0;
        #3 forever #40 wclk_o = ~wclk_o;
    end
    initial begin
        rclk_o = 1'b0;
        #21 forever #40 rclk_o = ~rclk_o;
    end
    initial begin
        wdata_o = 9'h000;
        first_write_enable_n_o = 1'b1;
        sec_o = 1'b1;
        ren_n_o = 1'b1;
    end
    // ****************
    // word transfers
    // ****************
    task automatic push(input logic [8:0] d);
        @(negedge wclk_o);
        @(posedge clk_i);
        wdata_o <= d;
        first_write_enable_n_o <= 1'b0;
        @(negedge wclk_o);
        @(posedge clk_i);
        wdata_o <= ~d;
        first_write_enable_n_o <= 1'b1;
    endtask
    task automatic pull(output logic [8:0] q);
        @(negedge rclk_o);
        @(posedge clk_i);
        ren_n_o <= 1'b0;
        @(negedge rclk_o);
        @(posedge clk_i);
        ren_n_o <= 1'b1;
        @(negedge clk_i);
        q = rdata_i;
    endtask
endmodule // dcf_link_host

/* File: tb/dcf_fifo_test.sv */
// self-checking bench of the dual-clock fifo flag block
module dcf_fifo_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rstn, cyc, stb, we, ack, irq, oen, wclk, rclk;
    logic        first_write_enable_n, sec, ren_n, rd_oe_n, ef_n, ff_n, ae_n, af_n;
    logic        second_read_enable_n = 1'b0;
    logic [3:0]  sel = 4'h3;
    logic [7:0]  adr;
    logic [31:0] dati, dato, rv;
    logic [8:0]  wdata, rdata, q;
    int          error_cnt, checks;

    dcf_fifo uut (.CLK_I(clk), .RSTN_I(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dati), .DAT_O(dato), .ACK_O(ack), .IRQ_O(irq),
        .WRITE_CLOCK_I(wclk), .WRITE_DATA_I(wdata), .FIRST_WRITE_ENABLE_N_I(first_write_enable_n),
        .SECOND_WRITE_ENABLE_OR_LOAD_I(sec), .READ_CLOCK_I(rclk),
        .FIRST_READ_ENABLE_N_I(ren_n), .SECOND_READ_ENABLE_N_I(ren_n | second_read_enable_n),
        .OUTPUT_ENABLE_N_I(oen), .READ_DATA_O(rdata), .READ_DATA_OE_N_O(rd_oe_n),
        .EMPTY_FLAG_N_O(ef_n), .FULL_FLAG_N_O(ff_n), .ALMOST_EMPTY_FLAG_N_O(ae_n),
        .ALMOST_FULL_FLAG_N_O(af_n));
    dcf_link_host host (.clk_i(clk), .rdata_i(rdata), .wclk_o(wclk), .rclk_o(rclk),
        .wdata_o(wdata), .first_write_enable_n_o(first_write_enable_n), .sec_o(sec), .ren_n_o(ren_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dati <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rv = dato;
        chk(ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask
    task automatic wait_ef(input int lim);
        int n;
        n = 0;
        while (ef_n !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(ef_n, 1'b1);
    endtask
    task automatic do_reset(input logic lvl);
        @(posedge clk);
        rstn <= 1'b0;
        host.sec_o <= lvl;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        chk({ef_n, ff_n, ae_n, af_n, rd_oe_n, rdata}, {5'b01011, 9'h000});
        rd_chk(8'h08, 32'h5);
        rd_chk(8'h00, 32'h7);
        rd_chk(8'h04, 32'h7);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h0);
        sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h3f09);
        sel <= 4'h3;
        rd_chk(8'h00, 32'h9);
        @(posedge clk);
        oen <= 1'b0;
        idle(5);
        chk({rd_oe_n, rdata}, 10'h000);
        $display("test reset done");
    endtask
    task automatic t_flow;
        wb(1'b1, 8'h00, 32'h4);
        host.push(9'h1a1);
        wait_ef(24);
        host.pull(q);
        chk(q, 9'h1a1);
        for (int i = 2; i < 5; i++) host.push(9'h1a0 + i);
        idle(12);
        chk(ae_n, 1'b0);
        host.push(9'h1a5);
        idle(12);
        chk(ae_n, 1'b1);
        rd_chk(8'h08, 32'h40000);
        for (int i = 2; i < 6; i++) begin
            host.pull(q);
            chk(q, 9'h1a0 + i);
            if (i == 2) begin
                idle(12);
                chk(ae_n, 1'b0);
            end
        end
        idle(12);
        chk(ef_n, 1'b0);
        $display("test flow done");
    endtask
    task automatic t_afull;
        wb(1'b1, 8'h04, 32'h3fff);
        host.push(9'h0b1);
        idle(12);
        chk(af_n, 1'b1);
        host.push(9'h0b2);
        idle(12);
        chk(af_n, 1'b0);
        host.pull(q);
        host.pull(q);
        idle(12);
        chk(af_n, 1'b1);
        host.push(9'h0b3);
        idle(24);
        @(posedge clk);
        second_read_enable_n <= 1'b1;
        host.pull(q);
        chk(q, 9'h0b2);
        @(posedge clk);
        second_read_enable_n <= 1'b0;
        host.pull(q);
        chk(q, 9'h0b3);
        $display("test afull done");
    endtask
    task automatic t_irq;
        wb(1'b1, 8'h0c, 32'hf);
        host.push(9'h0c1);
        wait_ef(24);
        host.pull(q);
        idle(12);
        host.pull(q);
        idle(4);
        rd_chk(8'h0c, 32'h9);
        chk(irq, 1'b0);
        wb(1'b1, 8'h10, 32'h8);
        idle(1);
        chk(irq, 1'b1);
        wb(1'b1, 8'h0c, 32'h8);
        idle(1);
        chk(irq, 1'b0);
        rd_chk(8'h0c, 32'h1);
        wb(1'b1, 8'h10, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_load;
        do_reset(1'b0);
        rd_chk(8'h08, 32'h15);
        host.push(9'h005);
        host.push(9'h006);
        idle(8);
        rd_chk(8'h00, 32'h5);
        rd_chk(8'h04, 32'h6);
        chk(ef_n, 1'b0);
        $display("test load done");
    endtask
    initial begin
        rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dati = 32'h0;
        oen = 1'b1;
        error_cnt = 0;
        checks = 0;
        do_reset(1'b1);
        t_reset;
        t_flow;
        t_afull;
        t_irq;
        t_load;
        give_verdict;
    end
    initial begin
        #200us;
        error_cnt++;
        give_verdict;
    end
endmodule // dcf_fifo_test
